/* dv/ssi_absolute_position_slave_bench.sv */
// Testbench joining master and slave ends back to back
`include "ssi_map.svh"
module ssi_absolute_position_slave_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import ssi_pkg::*;
   localparam int WORD = 22;
   logic mclk, reset, read_fault, start, busy, done;
   ssi_pos_t position;
   logic [15:0] speed_dm_s;
   logic [5:0] nclk;
   logic [31:0] rx_word;
   int fail_count, total_checks;
   // ********************
   // Ends and checker
   // ********************
   ssi_link_if link ();
   ssi_link_chk #(.WORD(WORD)) i_ssi_link_chk (.mclk(mclk), .reset(reset),
      .sclk(link.sclk), .sdata(link.sdata));
   ssi_slave #(.RES_SEL(`SSI_RES_5), .GRAY_CODE(1'b1)) i_ssi_slave (.mclk(mclk),
      .reset(reset), .position(position), .read_fault(read_fault),
      .speed_dm_s(speed_dm_s), .link(link.slave));
   ssi_master i_ssi_master (.mclk(mclk), .reset(reset), .start(start), .nclk(nclk),
      .busy(busy), .done(done), .rx_word(rx_word), .link(link.master));
   // Clock of 10 ns
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Verdict and end of run
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : conclude
   // Reflected binary of the position field
   function automatic logic [20:0] to_gray(input logic [20:0] b);
      return b ^ (b >> 1);
   endfunction : to_gray
   // Count back from reflected binary, scaled by 5 um per count
   function automatic logic [31:0] to_um(input logic [20:0] g);
      logic [20:0] b;
      b[20] = g[20];
      for (int i = 19; i >= 0; i--) begin
         b[i] = b[i + 1] ^ g[i];
      end
      return 32'(b) * 32'h5;
   endfunction : to_um
   // One read; position moves after capture and must not leak in
   task automatic xfer(input logic [22:0] p, input logic f, input logic [15:0] s,
      input int n, input logic ok);
      int t;
      position = p;
      read_fault = f;
      speed_dm_s = s;
      nclk = 6'(n);
      repeat (4) @(negedge mclk);
      start = 1'b1;
      @(negedge mclk);
      start = 1'b0;
      check({31'h0, busy}, 32'h1);
      t = 0;
      while (link.sclk === 1'b1 && t < 200) begin
         @(negedge mclk);
         t++;
      end
      check({31'h0, link.sclk}, 32'h0);
      repeat (10) @(negedge mclk);
      position = ~p;
      t = 0;
      while (done !== 1'b1 && t < 5000) begin
         @(negedge mclk);
         t++;
      end
      check({30'h0, busy, done}, 32'h1);
      check(rx_word, {10'h0, to_gray(p[20:0]), ok} << (n - WORD));
      check(to_um(21'(rx_word >> (n - WORD + 1))), 32'(p[20:0]) * 32'h5);
   endtask : xfer
   // ********************
   // Main sequence
   // ********************
   initial begin
      reset = 1'b1;
      start = 1'b0;
      nclk = 6'h16;
      position = '0;
      read_fault = 1'b0;
      speed_dm_s = 16'h0000;
      fail_count = 0;
      total_checks = 0;
      repeat (2) @(negedge mclk);
      reset = 1'b0;
      @(negedge mclk);
      check({31'h0, link.sdata}, 32'h1);
      check(rx_word, 32'h0);
      repeat (2000) @(negedge mclk);
      xfer(23'h755555, 1'b0, 16'h0000, WORD, 1'b1);
      xfer(23'h000001, 1'b1, 16'h0000, WORD, 1'b0);
      xfer(23'h1FFFFF, 1'b0, 16'h0046, WORD, 1'b1);
      xfer(23'h0C0F0F, 1'b0, 16'h0047, WORD, 1'b0);
      xfer(23'h012345, 1'b0, 16'h0000, WORD + 2, 1'b1);
      xfer(23'h000003, 1'b0, 16'h0000, WORD, 1'b1);
      conclude;
   end
   // Watchdog well past the expected run length
   initial begin
      repeat (60000) @(posedge mclk);
      fail_count++;
      conclude;
   end
endmodule : ssi_absolute_position_slave_bench

/* dv/ssi_link_chk.sv */
// Timing checker on the serial position link
module ssi_link_chk #(
   parameter int WORD = 22
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Link
   input wire logic sclk,
   input wire logic sdata
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [5:0] WORD6 = WORD[5:0];
   logic [11:0] hi_r;
   logic [11:0] lo_r;
   logic [5:0] rise_r;
   // ********************
   // Level and rise counters
   // ********************
   always_ff @(posedge mclk) begin
      if (reset) begin
         hi_r <= 12'h000;
         lo_r <= 12'h000;
         rise_r <= 6'h00;
      end else begin
         hi_r <= !sclk ? 12'h000 : hi_r + {11'h000, hi_r != 12'hFFF};
         lo_r <= sclk ? 12'h000 : lo_r + 12'h001;
         rise_r <= (hi_r > 12'h514) ? 6'h00 : rise_r + {5'h00, sclk && lo_r != 12'h000};
      end
   end
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);
   // Link rules
   idle_high_a: assert property ($fell(reset) |-> sclk && sdata)
      else $error("link not idle high after reset");
   edge_only_a: assert property ($changed(sdata) |-> sclk)
      else $error("data changed while clock low");
   bit_delay_a: assert property ($changed(sdata) && hi_r < 12'h010
      |-> hi_r inside {[12'h002:12'h006]}) else $error("data bit late after rise");
   mono_release_a: assert property ($rose(sdata) && hi_r > 12'h010
      |-> hi_r inside {[12'h4B0:12'h4BA]}) else $error("monoflop length wrong");
   mono_hold_a: assert property (hi_r > 12'h4BA |-> sdata)
      else $error("data not high after monoflop");
   clk_half_a: assert property ($rose(sclk) |-> lo_r inside {[12'h031:12'h033]})
      else $error("clock low phase wrong");
   pause_gap_a: assert property ($fell(sclk) && hi_r > 12'h040 |-> hi_r >= 12'h640)
      else $error("pause between bursts too short");
   zero_pad_a: assert property (rise_r > WORD6 && hi_r == 12'h008 |-> !sdata)
      else $error("surplus clock gave nonzero data");
endmodule : ssi_link_chk

/* pkg/ssi_link_if.sv */
// Link wires between master and slave
interface ssi_link_if;
   logic sclk;
   logic sdata;
   modport slave (input sclk, output sdata);
   modport master (output sclk, input sdata);
endinterface : ssi_link_if

/* pkg/ssi_map.svh */
// Constants of the absolute position serial link
`ifndef SSI_MAP_SVH
`define SSI_MAP_SVH
`define SSI_CLK_MHZ 100
`define SSI_WORD_MAX 24
`define SSI_POS_MAX 23
`define SSI_MONO_NS 12000
`define SSI_MONO_CYC ((`SSI_MONO_NS * `SSI_CLK_MHZ) / 1000)
`define SSI_PAUSE_NS 16000
`define SSI_PAUSE_CYC (((`SSI_PAUSE_NS * `SSI_CLK_MHZ) + 999) / 1000)
`define SSI_DIV_HALF 50
`define SSI_RES_50 3'h0
`define SSI_RES_10 3'h1
`define SSI_RES_5 3'h2
`define SSI_RES_2 3'h3
`define SSI_RES_1 3'h4
`define SSI_SPEED_7 16'h0046
`define SSI_SPEED_28 16'h001C
`define SSI_SPEED_14 16'h000E
`endif

/* pkg/ssi_pkg.sv */
// Types shared by both ends of the serial position link
package ssi_pkg;
   typedef logic [22:0] ssi_pos_t;
   typedef logic [2:0] ssi_res_t;
   typedef enum logic [1:0] {
      SSI_IDLE = 2'h0,
      SSI_SHIFT = 2'h1,
      SSI_MONO = 2'h3
   } ssi_slv_st_t;
   typedef enum logic [1:0] {
      SSI_M_IDLE = 2'h0,
      SSI_M_BURST = 2'h1,
      SSI_M_PAUSE = 2'h3
   } ssi_mst_st_t;
endpackage : ssi_pkg

/* src/ssi_master.sv */
// Master end: generates clock bursts and assembles received word
`include "ssi_map.svh"
module ssi_master (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // User side
   input wire logic start,
   input wire logic [5:0] nclk,
   output logic busy,
   output logic done,
   output logic [31:0] rx_word,
   // Link
   ssi_link_if.master link
);
   import ssi_pkg::*;

   // ****************************************************
   // Burst generator and receiver
   // ****************************************************
   localparam logic [15:0] PAUSE_CYC = 16'(`SSI_PAUSE_CYC);
   localparam logic [6:0] HALF = 7'(`SSI_DIV_HALF);

   ssi_mst_st_t st_r;
   ssi_mst_st_t st_nxt;
   logic [6:0] div_r;
   logic [6:0] div_nxt;
   logic [5:0] cnt_r;
   logic [5:0] cnt_nxt;
   logic [15:0] pau_r;
   logic [15:0] pau_nxt;
   logic sclk_r;
   logic sclk_nxt;
   logic [31:0] sh_r;
   logic [31:0] sh_nxt;
   logic busy_r;
   logic busy_nxt;
   logic done_r;
   logic done_nxt;
   logic [2:0] din_r;
   logic [2:0] din_nxt;
   logic din_lvl_r;
   logic din_lvl_nxt;

   // Divided clock, 1 MHz; sample data at end of high phase, on fall
   always_comb begin
      st_nxt = st_r;
      div_nxt = div_r;
      cnt_nxt = cnt_r;
      pau_nxt = pau_r;
      sclk_nxt = sclk_r;
      sh_nxt = sh_r;
      done_nxt = 1'b0;
      din_nxt = {din_r[1:0], link.sdata};
      // Data level counts once stages two and three agree
      din_lvl_nxt = din_lvl_r;
      if (din_r[1] == din_r[2]) begin
         din_lvl_nxt = din_r[2];
      end
      unique case (st_r)
         SSI_M_IDLE: begin
            sclk_nxt = 1'b1;
            if (start) begin
               st_nxt = SSI_M_BURST;
               div_nxt = 7'h00;
               cnt_nxt = nclk; // At least word length, n rising edges
               sh_nxt = 32'h00000000;
               sclk_nxt = 1'b0;
            end
         end
         SSI_M_BURST: begin
            if (div_r == HALF - 7'h01) begin
               div_nxt = 7'h00;
               if (sclk_r == 1'b0) begin
                  sclk_nxt = 1'b1;
                  cnt_nxt = cnt_r - 6'h01;
               end else if (cnt_r == 6'h00) begin
                  // Last data bit sampled half period after last rise
                  sh_nxt = {sh_r[30:0], din_lvl_r};
                  st_nxt = SSI_M_PAUSE;
                  pau_nxt = 16'h0000;
               end else begin
                  sh_nxt = {sh_r[30:0], din_lvl_r};
                  sclk_nxt = 1'b0;
               end
            end else begin
               div_nxt = div_r + 7'h01;
            end
         end
         SSI_M_PAUSE: begin
            if (pau_r == PAUSE_CYC) begin
               st_nxt = SSI_M_IDLE;
               done_nxt = 1'b1;
            end else begin
               pau_nxt = pau_r + 16'h0001;
            end
         end
         default: st_nxt = SSI_M_IDLE;
      endcase
      busy_nxt = (st_nxt != SSI_M_IDLE);
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         st_r <= SSI_M_IDLE;
         div_r <= 7'h00;
         cnt_r <= 6'h00;
         pau_r <= 16'h0000;
         sclk_r <= 1'b1;
         sh_r <= 32'h00000000;
         busy_r <= 1'b0;
         done_r <= 1'b0;
         din_r <= 3'h7;
         din_lvl_r <= 1'b1;
      end else begin
         st_r <= st_nxt;
         div_r <= div_nxt;
         cnt_r <= cnt_nxt;
         pau_r <= pau_nxt;
         sclk_r <= sclk_nxt;
         sh_r <= sh_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
         din_r <= din_nxt;
         din_lvl_r <= din_lvl_nxt;
      end
   end

   assign link.sclk = sclk_r;
   assign busy = busy_r;
   assign done = done_r;
   assign rx_word = sh_r; // Count times resolution is left to user
endmodule : ssi_master

/* src/ssi_slave.sv */
// Slave end: captures position and shifts it out on the serial link
`include "ssi_map.svh"
// Notes on behaviour
// - Clock idles high; first fall captures position
// - Following rise drives MSB first
// - Each further rise sends next bit
// - Master gives n rising edges
// - Surplus clocks send zeros after data
// - Monoflop timeout 12 us, no capture before
// - On timeout data goes high, ready
// - Master clocks at least word bits
// - Gray or binary fixed by variant
// - Word 19 to 24 bits by resolution
// - Position then trailing error bit
// - No zero, preset or direction function
// - Receiver scales count by resolution
// - Overspeed per variant counts as error
// - Master alone generates clock
// - Error bit high means no error
// - Master pauses 16 us between bursts
// - Clock between 100 kHz and 1 MHz
module ssi_slave #(
   parameter ssi_pkg::ssi_res_t RES_SEL = `SSI_RES_1,
   parameter bit GRAY_CODE = 1'b1
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Position source
   input wire ssi_pkg::ssi_pos_t position,
   input wire logic read_fault,
   input wire logic [15:0] speed_dm_s,
   // Link
   ssi_link_if.slave link
);
   import ssi_pkg::*;

   // ****************************************************
   // Word geometry and coding
   // ****************************************************
   // Word length per resolution variant
   function automatic logic [4:0] word_len(input ssi_res_t r);
      unique case (r)
         `SSI_RES_50: word_len = 5'h13;
         `SSI_RES_10: word_len = 5'h15;
         `SSI_RES_5: word_len = 5'h16;
         `SSI_RES_2: word_len = 5'h17;
         default: word_len = 5'h18;
      endcase
   endfunction : word_len

   // Overspeed limit in 0.1 m/s per variant
   function automatic logic [15:0] speed_lim(input ssi_res_t r);
      if (r == `SSI_RES_2) begin
         speed_lim = `SSI_SPEED_28;
      end else if (r == `SSI_RES_1) begin
         speed_lim = `SSI_SPEED_14;
      end else begin
         speed_lim = `SSI_SPEED_7;
      end
   endfunction : speed_lim

   // Reflected binary of the position field
   // The error bit never passes through here
   function automatic ssi_pos_t gray_of(input ssi_pos_t b);
      gray_of = b ^ (b >> 1);
   endfunction : gray_of

   // Word and field lengths of the chosen variant
   localparam logic [4:0] WLEN = word_len(RES_SEL);
   localparam logic [4:0] PLEN = WLEN - 5'h01;
   // Monoflop length in mclk cycles
   localparam logic [13:0] MONO_CYC = 14'(`SSI_MONO_CYC);

   // Bits of the raw count that belong to this variant's field
   localparam ssi_pos_t PMASK = 23'h7FFFFF >> (5'h17 - PLEN);

   // Left alignment: position MSB lands on bit 23, error bit follows
   localparam logic [4:0] POS_SHIFT = 5'h18 - PLEN;
   localparam logic [4:0] ERR_SHIFT = 5'h18 - WLEN;

   // ****************************************************
   // Clock pin synchroniser, three stages
   // ****************************************************
   // Pin stages and the agreed clock level
   logic [2:0] sync_r;
   logic [2:0] sync_nxt;
   logic clk_lvl_r;
   logic clk_lvl_nxt;
   logic fall;
   logic rise;

   // Shift in pin and track agreed level; a one-cycle glitch never agrees
   // Edges are seen two to three cycles late, far below a link half period
   always_comb begin
      sync_nxt = {sync_r[1:0], link.sclk};
      clk_lvl_nxt = clk_lvl_r;
      if (sync_r[1] == sync_r[2]) begin
         clk_lvl_nxt = sync_r[2];
      end
   end

   // Register synchroniser stages
   always_ff @(posedge mclk) begin
      if (reset) begin
         sync_r <= 3'h7;
         clk_lvl_r <= 1'b1; // Idle high
      end else begin
         sync_r <= sync_nxt;
         clk_lvl_r <= clk_lvl_nxt;
      end
   end

   // Edges of the agreed level
   assign fall = clk_lvl_r & ~clk_lvl_nxt;
   assign rise = ~clk_lvl_r & clk_lvl_nxt;

   // ****************************************************
   // Frame state machine
   // ****************************************************
   // Frame state
   ssi_slv_st_t st_r;
   ssi_slv_st_t st_nxt;

   // Shift word, MSB at bit 23
   logic [23:0] word_r;
   logic [23:0] word_nxt;

   // Monoflop timer, counts high clock time after the last rise
   logic [13:0] tmr_r;
   logic [13:0] tmr_nxt;
   logic sdata_r;
   logic sdata_nxt;

   // Field coding and the assembled frame
   ssi_pos_t raw;
   logic [22:0] coded;
   logic err_n;
   logic [23:0] frame;

   // Raw count of the field only, no offset applied
   // Upper bits belong to longer variants and must not reach the gray stage
   always_comb begin
      raw = position & PMASK;
      coded = GRAY_CODE ? gray_of(raw) : raw;
      err_n = ~(read_fault | (speed_dm_s > speed_lim(RES_SEL)));
      frame = ({1'b0, coded} << POS_SHIFT) | ({23'h000000, err_n} << ERR_SHIFT);
   end

   // Capture, shift and monoflop
   always_comb begin
      st_nxt = st_r;
      word_nxt = word_r;
      tmr_nxt = tmr_r;
      sdata_nxt = sdata_r;
      unique case (st_r)
         SSI_IDLE: begin
            // Line stays high; the first agreed fall captures the position
            if (fall) begin
               // Left aligned: position then error bit
               word_nxt = frame;
               st_nxt = SSI_SHIFT;
               tmr_nxt = 14'h0000;
            end
         end
         SSI_SHIFT: begin
            // Falls here belong to the burst; no recapture before release
            if (rise) begin
               sdata_nxt = word_r[23];
               word_nxt = {word_r[22:0], 1'b0}; // Zeros follow data
               tmr_nxt = 14'h0000;
            end else if (!clk_lvl_r) begin
               tmr_nxt = 14'h0000;
            end else if (tmr_r == MONO_CYC - 14'h0001) begin
               st_nxt = SSI_MONO;
            end else begin
               tmr_nxt = tmr_r + 14'h0001; // Burst end measured
            end
         end
         SSI_MONO: begin
            // Release the data line, then wait for a fresh fall
            sdata_nxt = 1'b1;
            st_nxt = SSI_IDLE;
         end
         default: st_nxt = SSI_IDLE;
      endcase
   end

   // Register frame state, word, timer and data pin
   always_ff @(posedge mclk) begin
      if (reset) begin
         st_r <= SSI_IDLE;
         word_r <= 24'h000000;
         tmr_r <= 14'h0000;
         sdata_r <= 1'b1;
      end else begin
         st_r <= st_nxt;
         word_r <= word_nxt;
         tmr_r <= tmr_nxt;
         sdata_r <= sdata_nxt;
      end
   end

   // ****************************************************
   // Link output
   // ****************************************************
   // Data pin comes straight from its register
   assign link.sdata = sdata_r;
endmodule : ssi_slave
